// File: mmc_defines.vh
// constants of the muting mode controller: register map, fields, reset values, timing
`ifndef MMC_DEFINES_VH
`define MMC_DEFINES_VH

// ==========================================================
// register byte addresses
`define MMC_ADDR_CTRL 4'h0
`define MMC_ADDR_STATUS 4'h4
`define MMC_ADDR_CONFIG 4'h8
`define MMC_ADDR_ELAPSED 4'hC

// ==========================================================
// control register fields
`define MMC_CTRL_MODE_LSB 0
`define MMC_CTRL_MODE_MSB 2
`define MMC_CTRL_VAR4 3
`define MMC_CTRL_SHORT_FILT 4
`define MMC_CTRL_CFB_EN 5
`define MMC_CTRL_TXRX 6
`define MMC_CTRL_RESET 7'h01

// ==========================================================
// muting types
`define MMC_TYPE_TIMED2 2'h0
`define MMC_TYPE_SEQ2 2'h1
`define MMC_TYPE_TIMED4 2'h2
`define MMC_TYPE_NONE 2'h3

// ==========================================================
// axi responses
`define MMC_RESP_OKAY 2'h0
`define MMC_RESP_SLVERR 2'h2

// ==========================================================
// timing: clock rate, prescaler tick, limits in seconds
`define MMC_CLK_HZ 100000000
`define MMC_TICK_S 1
`define MMC_TICK_CYCLES (`MMC_CLK_HZ * `MMC_TICK_S)
`define MMC_TO_SHORT_MIN 10
`define MMC_TO_LONG_H 100
`define MMC_EN_HIGH_MAX_H 8
`define MMC_TO_SHORT_S (`MMC_TO_SHORT_MIN * 60)
`define MMC_TO_LONG_S (`MMC_TO_LONG_H * 3600)
`define MMC_EN_HIGH_MAX_S (`MMC_EN_HIGH_MAX_H * 3600)
`define MMC_FILT_NORMAL_MS 3000
`define MMC_FILT_SHORT_MS 100
`define MMC_SEC_W 19

`endif

// File: mmc_tick.v
// one-second tick prescaler for the muting timers
`timescale 1ns/1ns
`default_nettype none
`include "mmc_defines.vh"

module mmc_tick #(
   parameter [31:0] TICK_CYCLES = `MMC_TICK_CYCLES
) (
   input wire clk,
   input wire rst,
   output reg tick
);
   reg [31:0] cnt_r;

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_r <= 32'h0;
         tick <= 1'b0;
      end else if (cnt_r >= TICK_CYCLES - 32'h1) begin
         cnt_r <= 32'h0;
         tick <= 1'b1;
      end else begin
         cnt_r <= cnt_r + 32'h1;
         tick <= 1'b0;
      end
   end
endmodule // mmc_tick

`default_nettype wire

// File: mmc_top.v
// muting mode controller: mode decode, muting timeouts, enable gate, override, axi4-lite regs
//
// Operation
// RL1: restart button overrides muting path after error
// RL2: modes 2,3,4,6 accept alternative second input
// RL3: control drives second signal only when needed
// RL4: enable high: next valid sequence starts muting
// RL5: enable low: muting start refused
// RL6: enable high over eight hours is error
// RL7: enable accepted only after seen low
// RL8: mode six excludes top beam, interlocks
// RL9: six selectable modes fix type and functions
// RL10: 2-sensor variant types and timeouts per mode
// RL11: per-mode function set per table
// RL12: 4-sensor variant types, no alt in six
// RL13: 4-sensor variant allows short 0.1 s filter
// RL14: input low at start grants no extension
// RL15: extension lasts while input stays low
// RL16: extension ends on high or 100 h
// RL17: after extension at most ten minutes more
// RL18: long timers run from one-second prescaler
//
// Design decisions made here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "mmc_defines.vh"

module mmc_top #(
   parameter [31:0] TICK_CYCLES = `MMC_TICK_CYCLES
) (
   input wire clk,
   input wire rst,
   input wire [3:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [3:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire muting_sensor_first,
   input wire muting_sensor_second,
   input wire muting_sensor_third,
   input wire muting_sensor_fourth,
   input wire mach_sensor_second,
   input wire enable_or_extension_input,
   input wire restart_button,
   input wire field_interrupted,
   input wire top_beam_interrupted,
   input wire seq_valid,
   input wire seq_end,
   output reg [3:0] sensors_to_detector,
   output reg [1:0] muting_type,
   output reg short_filter,
   output reg contactor_feedback_check,
   output reg muting_active,
   output reg muting_error,
   output reg override_active,
   output reg interlock
);
   // ==========================================================
   // mode decode: {cfb_sel, long_to, partial, gate, alt, ext, type[1:0]}
   function [7:0] mode_cfg;
      input [2:0] mode;
      input var4;
      reg [1:0] tmd;
      begin
         tmd = var4 ? `MMC_TYPE_TIMED4 : `MMC_TYPE_TIMED2; // [RL10] [RL12]
         case (mode)
            3'd1: mode_cfg = {1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, tmd};
            3'd2: mode_cfg = {1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, tmd};
            3'd3: mode_cfg = {1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, `MMC_TYPE_SEQ2};
            3'd4: mode_cfg = {1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, `MMC_TYPE_SEQ2};
            3'd5: mode_cfg = {1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, tmd};
            3'd6: mode_cfg = {1'b0, 1'b0, 1'b1, 1'b0, ~var4, 1'b1, tmd}; // [RL12]
            default: mode_cfg = {6'h00, `MMC_TYPE_NONE};
         endcase
      end
   endfunction

   // ==========================================================
   // pin synchronisers, two flops before any logic
   wire [8:0] pins_raw = {top_beam_interrupted, field_interrupted, restart_button,
      enable_or_extension_input, mach_sensor_second, muting_sensor_fourth,
      muting_sensor_third, muting_sensor_second, muting_sensor_first};
   reg [8:0] sync1_r;
   reg [8:0] sync2_r;
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         sync1_r <= 9'h000;
         sync2_r <= 9'h000;
      end else begin
         sync1_r <= pins_raw;
         sync2_r <= sync1_r;
      end
   end
   wire en_in = sync2_r[5];
   wire restart_in = sync2_r[6];
   wire field_int = sync2_r[7];
   wire top_int = sync2_r[8];

   // ==========================================================
   // control register and decoded mode
   reg [6:0] ctrl_r;
   wire [2:0] mode = ctrl_r[`MMC_CTRL_MODE_MSB:`MMC_CTRL_MODE_LSB];
   wire [7:0] cfg = mode_cfg(mode, ctrl_r[`MMC_CTRL_VAR4]); // [RL9] [RL11]
   wire ext_allowed = cfg[2];
   wire alt_allowed = cfg[3];
   wire gate_mode = cfg[4];
   wire partial_mode = cfg[5] & ctrl_r[`MMC_CTRL_TXRX];
   // limits are plain integers; cut them to the seconds counter width on purpose
   wire [31:0] to_long_w = `MMC_TO_LONG_S;
   wire [31:0] to_short_w = `MMC_TO_SHORT_S;
   wire [`MMC_SEC_W-1:0] base_to = cfg[6] ? to_long_w[`MMC_SEC_W-1:0]
      : to_short_w[`MMC_SEC_W-1:0];

   wire tick;
   mmc_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
      .clk(clk),
      .rst(rst),
      .tick(tick)
   ); // [RL18]

   // ==========================================================
   // muting supervision
   reg [`MMC_SEC_W-1:0] elapsed_r;
   reg [`MMC_SEC_W-1:0] post_r;
   reg [`MMC_SEC_W-1:0] en_hi_r;
   reg ext_armed_r;
   reg ext_on_r;
   reg post_on_r;
   reg en_seen_low_r;
   reg en_err_r;
   reg restart_d_r;

   // gate: enable high, seen low first, and no stuck-high error
   wire gate_ok = ~gate_mode | (en_in & en_seen_low_r & ~en_err_r); // [RL4] [RL5] [RL7]
   wire start_ok = seq_valid & ~muting_active & ~muting_error & gate_ok
      & (muting_type != `MMC_TYPE_NONE);
   wire ext_end = ext_on_r & (en_in | (elapsed_r >= `MMC_TO_LONG_S)); // [RL16]
   wire to_hit = post_on_r ? (post_r >= `MMC_TO_SHORT_S) // [RL17]
      : (~ext_on_r & ~ext_armed_r & (elapsed_r >= base_to))
      | (ext_armed_r & ~ext_on_r & (elapsed_r >= base_to));
   wire restart_rel = restart_d_r & ~restart_in;

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         muting_active <= 1'b0;
         muting_error <= 1'b1; // a power-up counts as a supply loss
         override_active <= 1'b0;
         interlock <= 1'b1;
         elapsed_r <= {`MMC_SEC_W{1'b0}};
         post_r <= {`MMC_SEC_W{1'b0}};
         en_hi_r <= {`MMC_SEC_W{1'b0}};
         ext_armed_r <= 1'b0;
         ext_on_r <= 1'b0;
         post_on_r <= 1'b0;
         en_seen_low_r <= 1'b0;
         en_err_r <= 1'b0;
         restart_d_r <= 1'b0;
         sensors_to_detector <= 4'h0;
         muting_type <= `MMC_TYPE_NONE;
         short_filter <= 1'b0;
         contactor_feedback_check <= 1'b0;
      end else begin
         restart_d_r <= restart_in;
         muting_type <= cfg[1:0];
         // shortened filter whenever the 4-sensor variant and the short filter bit are both set, in any mode
         short_filter <= ctrl_r[`MMC_CTRL_VAR4] & ctrl_r[`MMC_CTRL_SHORT_FILT]; // [RL13]
         contactor_feedback_check <= cfg[7] & ctrl_r[`MMC_CTRL_CFB_EN]; // [RL11]
         sensors_to_detector <= {sync2_r[3], sync2_r[2],
            sync2_r[1] | (alt_allowed & sync2_r[4]), sync2_r[0]}; // [RL2] [RL3]

         // enable input watch
         if (!en_in) begin
            en_seen_low_r <= 1'b1; // [RL7]
            en_hi_r <= {`MMC_SEC_W{1'b0}};
         end else if (tick && gate_mode) begin
            if (en_hi_r >= `MMC_EN_HIGH_MAX_S)
               en_err_r <= 1'b1; // [RL6]
            else
               en_hi_r <= en_hi_r + 1'b1;
         end

         // muting start, run and end
         if (start_ok) begin
            muting_active <= 1'b1;
            elapsed_r <= {`MMC_SEC_W{1'b0}};
            post_r <= {`MMC_SEC_W{1'b0}};
            ext_armed_r <= ext_allowed & en_in; // [RL14]
            ext_on_r <= 1'b0;
            post_on_r <= 1'b0;
         end else if (muting_active) begin
            if (tick) begin
               elapsed_r <= elapsed_r + 1'b1;
               if (post_on_r)
                  post_r <= post_r + 1'b1;
            end
            if (ext_armed_r && !en_in && !ext_on_r && !post_on_r && !to_hit)
               ext_on_r <= 1'b1; // [RL15]
            if (ext_end) begin
               ext_on_r <= 1'b0;
               ext_armed_r <= 1'b0;
               post_on_r <= 1'b1;
            end
            if (to_hit && !ext_on_r) begin
               muting_active <= 1'b0;
               muting_error <= 1'b1;
               post_on_r <= 1'b0;
               ext_armed_r <= 1'b0;
            end else if (seq_end) begin
               muting_active <= 1'b0;
               ext_on_r <= 1'b0;
               ext_armed_r <= 1'b0;
               post_on_r <= 1'b0;
            end
         end

         // override while the button is held after an error; release clears it
         if (muting_error && restart_in)
            override_active <= 1'b1; // [RL1]
         else
            override_active <= 1'b0;
         if (muting_error && restart_rel)
            muting_error <= 1'b0; // [RL1]
         if (en_err_r && restart_rel && !en_in)
            en_err_r <= 1'b0;

         // interlock: beam hit outside muting, or top beam in partial mode
         if ((field_int && !muting_active && !override_active && !restart_in)
            || (partial_mode && top_int && !override_active))
            interlock <= 1'b1; // [RL8]
         else if (restart_rel && !field_int)
            interlock <= 1'b0;
      end
   end

   // ==========================================================
   // axi4-lite slave; address and data taken in either order
   reg aw_have_r;
   reg w_have_r;
   reg [3:0] aw_addr_r;
   reg [31:0] w_data_r;
   reg [3:0] w_strb_r;
   wire [31:0] status_w = {25'h0, en_seen_low_r, en_err_r, post_on_r, ext_on_r,
      ext_armed_r, muting_error, muting_active};

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `MMC_RESP_OKAY;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= `MMC_RESP_OKAY;
         s_axi_rdata <= 32'h0;
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         aw_addr_r <= 4'h0;
         w_data_r <= 32'h0;
         w_strb_r <= 4'h0;
         ctrl_r <= `MMC_CTRL_RESET;
      end else begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_arready <= 1'b0;
         if (s_axi_awvalid && !aw_have_r && !s_axi_awready && !s_axi_bvalid) begin
            s_axi_awready <= 1'b1;
            aw_have_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !w_have_r && !s_axi_wready && !s_axi_bvalid) begin
            s_axi_wready <= 1'b1;
            w_have_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end
         if (aw_have_r && w_have_r && !s_axi_bvalid) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (aw_addr_r == `MMC_ADDR_CTRL) begin
               s_axi_bresp <= `MMC_RESP_OKAY;
               // mode cannot change under running muting
               if (w_strb_r[0] && !muting_active)
                  ctrl_r <= w_data_r[6:0];
            end else if (aw_addr_r == `MMC_ADDR_STATUS || aw_addr_r == `MMC_ADDR_CONFIG
               || aw_addr_r == `MMC_ADDR_ELAPSED)
               s_axi_bresp <= `MMC_RESP_OKAY;
            else
               s_axi_bresp <= `MMC_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;

         if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `MMC_RESP_OKAY;
            if (s_axi_araddr == `MMC_ADDR_CTRL)
               s_axi_rdata <= {25'h0, ctrl_r};
            else if (s_axi_araddr == `MMC_ADDR_STATUS)
               s_axi_rdata <= status_w;
            else if (s_axi_araddr == `MMC_ADDR_CONFIG)
               s_axi_rdata <= {24'h0, cfg};
            else if (s_axi_araddr == `MMC_ADDR_ELAPSED)
               s_axi_rdata <= {13'h0, elapsed_r};
            else begin
               s_axi_rdata <= 32'h0;
               s_axi_rresp <= `MMC_RESP_SLVERR;
            end
         end else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end
endmodule // mmc_top

`default_nettype wire

// File: mmc_chk.sv
// assertion checker on the ports of the muting mode controller
`timescale 1ns/1ns
`default_nettype none
`include "mmc_defines.vh"
// ==================================================
// checker
module mmc_chk #(
   parameter [31:0] TICK_CYCLES = 10
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic seq_valid,
   input wire logic muting_active,
   input wire logic muting_error,
   input wire logic override_active,
   input wire logic short_filter,
   input wire logic [1:0] muting_type,
   input wire logic s_axi_awready,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_wr_taken; s_axi_awready && s_axi_wready; endsequence
   sequence s_wr_resp; ##1 s_axi_bvalid; endsequence
   property p_wr; s_wr_taken |-> s_wr_resp; endproperty
   a_wr: assert property (p_wr) else $error("write response late");
   property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_bhold: assert property (p_bhold) else $error("write response dropped");
   property p_rd; s_axi_arready |-> s_axi_rvalid && $past(s_axi_arvalid); endproperty
   a_rd: assert property (p_rd) else $error("read answer wrong");
   property p_rhold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
         && $stable(s_axi_rresp);
   endproperty
   a_rhold: assert property (p_rhold) else $error("read data dropped");
   property p_start; $rose(muting_active) |-> $past(seq_valid); endproperty
   a_start: assert property (p_start) else $error("muting without sequence");
   property p_err_stop; $rose(muting_error) |-> !muting_active; endproperty
   a_err_stop: assert property (p_err_stop) else $error("muting kept after error");
   property p_no_start; muting_error && seq_valid |=> !muting_active; endproperty
   a_no_start: assert property (p_no_start) else $error("muting started in error");
   property p_ovr; $rose(override_active) |-> muting_error; endproperty
   a_ovr: assert property (p_ovr) else $error("override without error");
   property p_short; short_filter |-> muting_type != `MMC_TYPE_TIMED2; endproperty
   a_short: assert property (p_short) else $error("short filter in 2-sensor variant");
endmodule // mmc_chk
bind mmc_top mmc_chk #(.TICK_CYCLES(TICK_CYCLES)) mmc_chk_i (
   .clk, .rst, .seq_valid, .muting_active, .muting_error, .override_active,
   .short_filter, .muting_type, .s_axi_awready, .s_axi_wready, .s_axi_bvalid,
   .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
   .s_axi_rready, .s_axi_rdata, .s_axi_rresp);
`default_nettype wire

// File: mmc_far.sv
// far-side model: muting sensors, machine control and restart button
`timescale 1ns/1ns
`default_nettype none
// ==================================================
// far side
module mmc_far (
   input wire logic clk,
   input wire logic rst,
   input wire logic obj,
   input wire logic mach,
   input wire logic en,
   input wire logic btn,
   output logic muting_sensor_first,
   output logic muting_sensor_second,
   output logic muting_sensor_third,
   output logic muting_sensor_fourth,
   output logic mach_sensor_second,
   output logic enable_or_extension_input,
   output logic restart_button
);
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         muting_sensor_first <= 1'h0;
         muting_sensor_second <= 1'h0;
         muting_sensor_third <= 1'h0;
         muting_sensor_fourth <= 1'h0;
         mach_sensor_second <= 1'h0;
         enable_or_extension_input <= 1'h0;
         restart_button <= 1'h0;
      end else begin
         // a passing load covers every sensor; free sensors pull low
         muting_sensor_first <= obj;
         muting_sensor_second <= obj;
         muting_sensor_third <= obj;
         muting_sensor_fourth <= obj;
         // the control raises its signal only while it wants a passage
         mach_sensor_second <= mach;
         enable_or_extension_input <= en;
         restart_button <= btn;
      end
   end
endmodule // mmc_far
`default_nettype wire

// File: test_muting_mode_controller.sv
// self-checking bench for the muting mode controller
`timescale 1ns/1ns
`default_nettype none
`include "mmc_defines.vh"
// ==================================================
// bench
module test_muting_mode_controller;
   localparam int TK = 2;
   logic clk = 0;
   logic rst = 1;
   logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, muting_type;
   logic muting_sensor_first, muting_sensor_second, muting_sensor_third;
   logic muting_sensor_fourth, mach_sensor_second, enable_or_extension_input, restart_button;
   logic field_interrupted = 0, top_beam_interrupted = 0, seq_valid = 0, seq_end = 0;
   logic [3:0] sensors_to_detector;
   logic short_filter, contactor_feedback_check, muting_active, muting_error;
   logic override_active, interlock;
   logic obj = 0, mach = 0, en = 0, btn = 0;
   int fail_count = 0, n_tests = 0;
   always #5 clk = ~clk;
   mmc_top #(.TICK_CYCLES(TK)) mmc_top_i (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .muting_sensor_first, .muting_sensor_second,
      .muting_sensor_third, .muting_sensor_fourth, .mach_sensor_second,
      .enable_or_extension_input, .restart_button, .field_interrupted, .top_beam_interrupted,
      .seq_valid, .seq_end, .sensors_to_detector, .muting_type, .short_filter,
      .contactor_feedback_check, .muting_active, .muting_error, .override_active, .interlock);
   mmc_far mmc_far_i (.clk, .rst, .obj, .mach, .en, .btn, .muting_sensor_first,
      .muting_sensor_second, .muting_sensor_third, .muting_sensor_fourth, .mach_sensor_second,
      .enable_or_extension_input, .restart_button);
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      n_tests++;
      if (s !== e) begin
         fail_count++;
         $display("unexpected %s: expected %h seen %h", nm, e, s);
      end
   endtask
   // checks read pre-edge values, which are settled since the design updates by nba
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
   endtask
   // the handshake waits in wr and rd end only on the answer; the watchdog catches a hang
   task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] e);
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge clk);
         if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
         if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
      end while (s_axi_bvalid !== 1'h1);
      s_axi_bready <= 1'h0;
      chk("bresp", e, s_axi_bresp);
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge clk);
         if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
      end while (s_axi_rvalid !== 1'h1);
      s_axi_rready <= 1'h0;
      chk("rdata", e, s_axi_rdata);
      chk("rresp", er, s_axi_rresp);
   endtask
   task automatic mute_on;
      obj <= 1'h1;
      wt(4);
      seq_valid <= 1'h1;
      wt(1);
      seq_valid <= 1'h0;
      wt(2);
   endtask
   task automatic mute_off;
      seq_end <= 1'h1;
      wt(1);
      seq_end <= 1'h0;
      obj <= 1'h0;
      wt(3);
   endtask
   task automatic clr_err(input logic ov);
      btn <= 1'h1;
      wt(6);
      chk("override", ov, override_active);
      field_interrupted <= 1'h0;
      btn <= 1'h0;
      wt(6);
      chk("error", 0, muting_error);
      chk("interlock", 0, interlock);
   endtask
   task automatic wait_err(input int lim);
      int n;
      n = 0;
      while (muting_error !== 1'h1 && n < lim) begin
         wt(1);
         n++;
      end
      chk("error", 1, muting_error);
      chk("active", 0, muting_active);
   endtask
   task automatic t_reset;
      chk("type", `MMC_TYPE_TIMED2, muting_type);
      chk("error", 1, muting_error);
      rd(`MMC_ADDR_CTRL, 32'h1, `MMC_RESP_OKAY);
      rd(4'h2, 32'h0, `MMC_RESP_SLVERR);
      wr(4'h2, 32'h0, `MMC_RESP_SLVERR);
      wr(`MMC_ADDR_STATUS, 32'hFF, `MMC_RESP_OKAY);
      clr_err(1);
   endtask
   task automatic t_modes;
      logic [1:0] ty;
      logic alt_e;
      mach <= 1'h1;
      for (int v = 0; v < 2; v++) begin
         for (int m = 0; m < 8; m++) begin
            ty = (m == 0 || m == 7) ? `MMC_TYPE_NONE : (m == 3 || m == 4) ? `MMC_TYPE_SEQ2 :
               v ? `MMC_TYPE_TIMED4 : `MMC_TYPE_TIMED2;
            alt_e = m inside {2, 3, 4} || (m == 6 && !v);
            wr(`MMC_ADDR_CTRL, m | (v << 3) | 32'h30, `MMC_RESP_OKAY);
            wt(5);
            chk("type", ty, muting_type);
            if (m > 0 && m < 7) begin
               chk("short", v, short_filter);
               chk("cfb", m != 4 && m != 6, contactor_feedback_check);
               chk("alt", {alt_e, 1'h0}, sensors_to_detector);
            end
         end
      end
      mach <= 1'h0;
      wr(`MMC_ADDR_CTRL, 32'h1, `MMC_RESP_OKAY);
   endtask
   task automatic t_gate;
      wr(`MMC_ADDR_CTRL, 32'h5, `MMC_RESP_OKAY);
      mute_on;
      chk("active", 0, muting_active);
      en <= 1'h1;
      wt(5);
      mute_on;
      chk("active", 1, muting_active);
      chk("sensors", 4'hF, sensors_to_detector);
      mute_off;
      chk("active", 0, muting_active);
      en <= 1'h0;
   endtask
   task automatic t_timeout;
      wr(`MMC_ADDR_CTRL, 32'h1, `MMC_RESP_OKAY);
      mute_on;
      wt(1150);
      chk("active", 1, muting_active);
      wait_err(100);
      rd(`MMC_ADDR_ELAPSED, 32'h258, `MMC_RESP_OKAY);
      obj <= 1'h0;
      field_interrupted <= 1'h1;
      clr_err(1);
   endtask
   task automatic t_ext;
      en <= 1'h1;
      wt(4);
      mute_on;
      en <= 1'h0;
      wt(1300);
      chk("active", 1, muting_active);
      en <= 1'h1;
      wt(1150);
      chk("active", 1, muting_active);
      wait_err(100);
      obj <= 1'h0;
      en <= 1'h0;
      clr_err(1);
   endtask
   task automatic t_long;
      wr(`MMC_ADDR_CTRL, 32'h2, `MMC_RESP_OKAY);
      mute_on;
      wt(1300);
      chk("active", 1, muting_active);
      wr(`MMC_ADDR_CTRL, 32'h1, `MMC_RESP_OKAY);
      rd(`MMC_ADDR_CTRL, 32'h2, `MMC_RESP_OKAY);
      mute_off;
   endtask
   task automatic t_partial;
      wr(`MMC_ADDR_CTRL, 32'h46, `MMC_RESP_OKAY);
      rd(`MMC_ADDR_CONFIG, 32'h2C, `MMC_RESP_OKAY);
      mute_on;
      top_beam_interrupted <= 1'h1;
      wt(5);
      chk("interlock", 1, interlock);
      chk("active", 1, muting_active);
      top_beam_interrupted <= 1'h0;
      mute_off;
      clr_err(0);
   endtask
   // enable held high past eight hours of ticks blocks muting until cleared
   task automatic t_en_stuck;
      wr(`MMC_ADDR_CTRL, 32'h5, `MMC_RESP_OKAY);
      en <= 1'h1;
      wt(57500);
      rd(`MMC_ADDR_STATUS, 32'h40, `MMC_RESP_OKAY);
      wt(200);
      rd(`MMC_ADDR_STATUS, 32'h60, `MMC_RESP_OKAY);
      mute_on;
      chk("active", 0, muting_active);
      obj <= 1'h0;
      en <= 1'h0;
      clr_err(0);
      rd(`MMC_ADDR_STATUS, 32'h40, `MMC_RESP_OKAY);
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   initial begin
      wt(20);
      rst <= 1'h0;
      wt(3);
      t_reset;
      t_modes;
      t_gate;
      t_timeout;
      t_ext;
      t_long;
      t_partial;
      t_en_stuck;
      final_report;
   end
   // the run needs about 64000 cycles; this leaves ample margin
   initial begin
      #800000;
      fail_count++;
      final_report;
   end
endmodule // test_muting_mode_controller
`default_nettype wire
